// file: src/cgsc_pkg.sv
/*
  Shared constants and types of the serial clock configuration block.
  Assumes a single system clock domain; the serial link is sampled, not clocked.
*/
package cgsc_pkg;

  // Register indices on the serial link
  localparam logic [7:0] IDX_FUNC = 8'h00;
  localparam logic [7:0] IDX_HOST = 8'h01;
  localparam logic [7:0] IDX_BUS  = 8'h02;
  localparam logic [7:0] IDX_MEM  = 8'h03;
  localparam logic [7:0] IDX_PERI = 8'h05;

  // Field positions in the function register
  localparam int FN_SPREAD_DOWN = 7;
  localparam int FN_SRC         = 3;
  localparam int FN_CODE_MSB    = 2;
  localparam int FN_SPREAD_EN   = 1;
  localparam int FN_TRISTATE    = 0;

  // Values after reset, reserved bits and unmapped reads
  localparam logic [7:0] FUNC_RST    = 8'h00;
  localparam logic [2:0] HOST_EN_RST = 3'h7;
  localparam logic [5:0] BUS_EN_RST  = 6'h3f;
  localparam logic [7:0] MEM_EN_RST  = 8'hff;
  localparam logic [3:0] PERI_EN_RST = 4'hf;
  localparam logic [3:0] HOST_RSV    = 4'hf;
  localparam logic       RSV_BIT     = 1'h1;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Bit counter values and strap capture delay after reset release
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] LAT_WAIT      = 2'h3;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_IDX, ST_WR, ST_RD} cgsc_st_e;

  // Power-on strap pins
  typedef struct packed {
    logic fs2;
    logic fs1;
    logic fs0;
    logic mem_sel;
  } cgsc_pins_s;

  // Writable register state
  typedef struct packed {
    logic [7:0] func;
    logic [2:0] host;
    logic [5:0] bus;
    logic [7:0] mem;
    logic [3:0] peri;
  } cgsc_regs_s;

  // Controls handed to the synthesizer and output drivers
  typedef struct packed {
    logic       spread_down;
    logic       spread_en;
    logic       tristate;
    logic       freq_from_reg;
    logic [3:0] freq_code;
    logic [2:0] host_en;
    logic [5:0] bus_en;
    logic [7:0] mem_en;
    logic [3:0] peri_en;
  } cgsc_cfg_s;

endpackage : cgsc_pkg

// file: src/cgsc_regs.sv
/*
  Serially programmed configuration registers with a two-wire slave.
  Assumes SCL, SDA and strap pins arrive asynchronously and that the
  surrounding pad resolves SDA from the active-low output enable.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Bit 7 picks centre or down spread
// - Code is bits 2,6,5,4, bit 2 first
// - Bit 3 picks strap pins or register code
// - Bit 1 turns spread modulation on
// - Bit 0 tristates all clock outputs
// - After power-up straps set the frequency
// - Unwritten code bits read back revision code
// - Enable one runs clock, zero holds low
// - Host enables bits 3..1, upper bits reserved ones
// - Host register bit 0 shows strap zero
// - Memory enables bit n gates output n
// - Peripheral bits 4,2..0 gate outputs, reserved ones
// - Peripheral bits 6 and 3 show straps
// - Bus bit 6 free-running, bits 4..0 outputs
// - Bus bit 7 shows strap one
// - Function register resets to zero
// - All bytes reached over two-wire link
module cgsc_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h69,
  parameter logic [3:0] REV_ID   = 4'h3  // Arbitrary value
) (
  input  wire logic                I_CLK_SYS,
  input  wire logic                I_SYS_RST,
  input  wire logic                I_SCL,
  input  wire logic                I_SDA,
  output logic                     O_SDA,
  output logic                     O_SDA_OE_N,
  input  wire cgsc_pkg::cgsc_pins_s I_PINS,
  output cgsc_pkg::cgsc_cfg_s      O_CFG
);

  logic [5:0]           sync1_q;
  logic [5:0]           sync2_q;
  logic                 scl_p_q;
  logic                 sda_p_q;
  logic                 scl_s;
  logic                 sda_s;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start;
  logic                 stop;
  cgsc_pkg::cgsc_pins_s pins_s;
  cgsc_pkg::cgsc_pins_s lat_q, lat_d;
  logic [1:0]           lat_cnt_q, lat_cnt_d;
  logic                 lat_done_q, lat_done_d;
  cgsc_pkg::cgsc_st_e   st_q, st_d;
  logic [3:0]           cnt_q, cnt_d;
  logic                 ack_q, ack_d;
  logic                 mack_q, mack_d;
  logic [7:0]           sh_q, sh_d;
  logic [7:0]           tx_q, tx_d;
  logic [7:0]           idx_q, idx_d;
  logic                 oen_q, oen_d;
  logic                 b0w_q, b0w_d;
  cgsc_pkg::cgsc_regs_s regs_q, regs_d;
  cgsc_pkg::cgsc_cfg_s  cfg_q, cfg_d;
  logic                 wr_en;
  logic                 rd_load;
  logic [7:0]           rd_byte;

  // Pins pass two flops; the second stage, plus a third one for SCL and SDA, feeds logic
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sync1_q <= 6'h3f;
      sync2_q <= 6'h3f;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync1_q <= {I_SCL, I_SDA, I_PINS};
      sync2_q <= sync1_q;
      scl_p_q <= sync2_q[5];
      sda_p_q <= sync2_q[4];
    end
  end

  assign scl_s    = sync2_q[5];
  assign sda_s    = sync2_q[4];
  assign pins_s   = sync2_q[3:0];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Straps are caught once, after the synchroniser has filled
  always_comb begin
    lat_d      = lat_q;
    lat_cnt_d  = lat_cnt_q;
    lat_done_d = lat_done_q;
    if (!lat_done_q) begin
      if (lat_cnt_q == cgsc_pkg::LAT_WAIT) begin
        lat_d      = pins_s;
        lat_done_d = 1'b1;
      end else begin
        lat_cnt_d = 2'(lat_cnt_q + 2'h1);
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lat_q      <= '0;
      lat_cnt_q  <= 2'h0;
      lat_done_q <= 1'b0;
    end else begin
      lat_q      <= lat_d;
      lat_cnt_q  <= lat_cnt_d;
      lat_done_q <= lat_done_d;
    end
  end

  // Read mux; mirrors and reserved bits come from straps and constants
  always_comb begin
    unique case (idx_q)
      cgsc_pkg::IDX_FUNC: begin
        rd_byte = regs_q.func;
        if (!b0w_q) begin
          rd_byte[6:4] = REV_ID[2:0];
          rd_byte[cgsc_pkg::FN_CODE_MSB] = REV_ID[3];
        end
      end
      cgsc_pkg::IDX_HOST:
        rd_byte = {cgsc_pkg::HOST_RSV, regs_q.host, lat_q.fs0};
      cgsc_pkg::IDX_BUS:
        rd_byte = {lat_q.fs1, regs_q.bus[5], cgsc_pkg::RSV_BIT,
                   regs_q.bus[4:0]};
      cgsc_pkg::IDX_MEM:  rd_byte = regs_q.mem;
      cgsc_pkg::IDX_PERI:
        rd_byte = {cgsc_pkg::RSV_BIT, lat_q.fs2, cgsc_pkg::RSV_BIT,
                   regs_q.peri[3], lat_q.mem_sel, regs_q.peri[2:0]};
      default: rd_byte = cgsc_pkg::UNMAPPED_RD;
    endcase
  end

  // Two-wire slave: index byte, then auto-incrementing data bytes
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    ack_d   = ack_q;
    mack_d  = mack_q;
    sh_d    = sh_q;
    tx_d    = tx_q;
    idx_d   = idx_q;
    oen_d   = oen_q;
    regs_d  = regs_q;
    b0w_d   = b0w_q;
    wr_en   = 1'b0;
    rd_load = 1'b0;
    if (start) begin
      st_d  = cgsc_pkg::ST_ADDR;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oen_d = 1'b1;
    end else if (stop) begin
      st_d  = cgsc_pkg::ST_IDLE;
      ack_d = 1'b0;
      oen_d = 1'b1;
    end else if (scl_rise && st_q != cgsc_pkg::ST_IDLE) begin
      if (ack_q) begin
        if (st_q == cgsc_pkg::ST_RD) mack_d = ~sda_s;
      end else if (cnt_q != cgsc_pkg::BITS_PER_BYTE) begin
        sh_d  = {sh_q[6:0], sda_s};
        cnt_d = 4'(cnt_q + 4'h1);
      end
    end else if (scl_fall && st_q != cgsc_pkg::ST_IDLE) begin
      if (ack_q) begin
        ack_d = 1'b0;
        cnt_d = 4'h0;
        oen_d = 1'b1;
        if (st_q == cgsc_pkg::ST_RD) begin
          // A master not-acknowledge ends the read burst
          if (mack_q) begin
            rd_load = 1'b1;
            tx_d    = rd_byte;
            idx_d   = 8'(idx_q + 8'h1);
            oen_d   = rd_byte[7];
          end else begin
            st_d = cgsc_pkg::ST_IDLE;
          end
        end
      end else if (cnt_q == cgsc_pkg::BITS_PER_BYTE) begin
        unique case (st_q)
          cgsc_pkg::ST_ADDR: begin
            if (sh_q[7:1] == DEV_ADDR) begin
              ack_d  = 1'b1;
              oen_d  = 1'b0;
              mack_d = 1'b1;
              st_d   = sh_q[0] ? cgsc_pkg::ST_RD : cgsc_pkg::ST_IDX;
            end else begin
              st_d = cgsc_pkg::ST_IDLE;
            end
          end
          cgsc_pkg::ST_IDX: begin
            idx_d = sh_q;
            ack_d = 1'b1;
            oen_d = 1'b0;
            st_d  = cgsc_pkg::ST_WR;
          end
          cgsc_pkg::ST_WR: begin
            wr_en = 1'b1;
            ack_d = 1'b1;
            oen_d = 1'b0;
            idx_d = 8'(idx_q + 8'h1);
          end
          cgsc_pkg::ST_RD: begin
            ack_d = 1'b1;
            oen_d = 1'b1;
          end
          cgsc_pkg::ST_IDLE: begin
          end
        endcase
      end else if (st_q == cgsc_pkg::ST_RD) begin
        tx_d  = {tx_q[6:0], 1'b0};
        oen_d = tx_q[6];
      end
    end
    // Only implemented function and enable bits take writes
    if (wr_en) begin
      case (idx_q)
        cgsc_pkg::IDX_FUNC: begin
          regs_d.func = sh_q;
          b0w_d       = 1'b1;
        end
        cgsc_pkg::IDX_HOST: regs_d.host = sh_q[3:1];
        cgsc_pkg::IDX_BUS:  regs_d.bus  = {sh_q[6], sh_q[4:0]};
        cgsc_pkg::IDX_MEM:  regs_d.mem  = sh_q;
        cgsc_pkg::IDX_PERI: regs_d.peri = {sh_q[4], sh_q[2:0]};
        default: ;
      endcase
    end
  end

  // Controls are registered from the next register state, so they change in the same cycle as it
  always_comb begin
    cfg_d.spread_down   = regs_d.func[cgsc_pkg::FN_SPREAD_DOWN];
    cfg_d.spread_en     = regs_d.func[cgsc_pkg::FN_SPREAD_EN];
    cfg_d.tristate      = regs_d.func[cgsc_pkg::FN_TRISTATE];
    cfg_d.freq_from_reg = regs_d.func[cgsc_pkg::FN_SRC];
    // Source select, code order, bit 2 first
    cfg_d.freq_code = cfg_d.freq_from_reg
      ? {regs_d.func[cgsc_pkg::FN_CODE_MSB], regs_d.func[6:4]}
      : {lat_d.mem_sel, lat_d.fs2, lat_d.fs1, lat_d.fs0};
    cfg_d.host_en = regs_d.host;
    cfg_d.bus_en  = regs_d.bus;
    cfg_d.mem_en  = regs_d.mem;
    cfg_d.peri_en = regs_d.peri;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_q   <= cgsc_pkg::ST_IDLE;
      cnt_q  <= 4'h0;
      ack_q  <= 1'b0;
      mack_q <= 1'b0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      idx_q  <= 8'h00;
      oen_q  <= 1'b1;
      b0w_q  <= 1'b0;
      regs_q <= {cgsc_pkg::FUNC_RST, cgsc_pkg::HOST_EN_RST,
                 cgsc_pkg::BUS_EN_RST, cgsc_pkg::MEM_EN_RST,
                 cgsc_pkg::PERI_EN_RST};
      cfg_q  <= {8'h00, cgsc_pkg::HOST_EN_RST, cgsc_pkg::BUS_EN_RST,
                 cgsc_pkg::MEM_EN_RST, cgsc_pkg::PERI_EN_RST};
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      ack_q  <= ack_d;
      mack_q <= mack_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      idx_q  <= idx_d;
      oen_q  <= oen_d;
      b0w_q  <= b0w_d;
      regs_q <= regs_d;
      cfg_q  <= cfg_d;
    end
  end

  // Open drain: the line is only ever pulled low
  assign O_SDA      = 1'b0;
  assign O_SDA_OE_N = oen_q;
  assign O_CFG      = cfg_q;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  a_tristate_write: assert property (wr_en && idx_q == cgsc_pkg::IDX_FUNC
    |=> O_CFG.tristate == $past(sh_q[0])) else $error("tristate");
  a_spread_write: assert property (wr_en && idx_q == cgsc_pkg::IDX_FUNC
    |=> O_CFG.spread_en == $past(sh_q[1])) else $error("spread");
  a_spread_type: assert property (wr_en && idx_q == cgsc_pkg::IDX_FUNC
    |=> O_CFG.spread_down == $past(sh_q[7])) else $error("type");
  a_code_order: assert property (O_CFG.freq_from_reg |->
    O_CFG.freq_code == {regs_q.func[2], regs_q.func[6:4]})
    else $error("code order");
  a_strap_source: assert property (lat_done_q && !regs_q.func[3] |->
    O_CFG.freq_code == {lat_q.mem_sel, lat_q.fs2, lat_q.fs1, lat_q.fs0})
    else $error("strap source");
  a_boot_straps: assert property (!b0w_q |-> !O_CFG.freq_from_reg)
    else $error("boot source");
  a_rev_read: assert property (rd_load && idx_q == cgsc_pkg::IDX_FUNC
    && !b0w_q |=> tx_q[6:4] == REV_ID[2:0] && tx_q[2] == REV_ID[3])
    else $error("revision");
  a_host_write: assert property (wr_en && idx_q == cgsc_pkg::IDX_HOST
    |=> O_CFG.host_en == $past(sh_q[3:1])) else $error("host en");
  a_mem_write: assert property (wr_en && idx_q == cgsc_pkg::IDX_MEM
    |=> O_CFG.mem_en == $past(sh_q)) else $error("mem en");
  a_mirror_stable: assert property (lat_done_q |=> $stable(lat_q))
    else $error("strap mirror");
  a_addr_ack: assert property (scl_fall && st_q == cgsc_pkg::ST_ADDR
    && !ack_q && cnt_q == 4'h8 && sh_q[7:1] == DEV_ADDR && !start && !stop
    |=> !O_SDA_OE_N [*2]) else $error("no ack");

  c_write: cover property (wr_en && idx_q == cgsc_pkg::IDX_FUNC);
  c_read: cover property (rd_load && idx_q == cgsc_pkg::IDX_PERI);
  c_nack: cover property (st_q == cgsc_pkg::ST_RD ##1
    st_q == cgsc_pkg::ST_IDLE);

endmodule : cgsc_regs

// file: testbench/cgsc_host.sv
/*
  Two-wire host model that drives the configuration link.
  Assumes the bench forms the data line from both pulls and a pull-up.
*/
`timescale 1ns/1ps
module cgsc_host (
  output logic       scl,
  output logic       sda_o,
  input  wire logic  sda_i,
  output logic       rd_done,
  output logic [7:0] rd_byte
);
  // Quarter of the 125 ns link period
  localparam realtime QTR = 31.25;

  // Link idles released, clock parked high between frames
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end

  task automatic start_cond();
    sda_o = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_o = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask : start_cond

  task automatic stop_cond();
    sda_o = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_o = 1'b1;
    #QTR;
  endtask : stop_cond

  // Data only moves while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    sda_o = b;
    #QTR scl = 1'b1;
    #QTR s = sda_i;
    #QTR scl = 1'b0;
    #QTR;
  endtask : clk_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      rd_byte[i] = s;
    end
    rd_done = 1'b1;
    // ack all but the final byte
    clk_bit(last, s);
    rd_done = 1'b0;
  endtask : recv_byte
endmodule : cgsc_host

// file: testbench/clock_gen_serial_config_regs_tb.sv
/*
  Self-checking bench: host model writes and reads every register.
  Assumes open-drain data with a pull-up, modelled by an AND below.
*/
`timescale 1ns/1ps
module clock_gen_serial_config_regs_tb;
  localparam logic [3:0] REV = 4'ha;  // Arbitrary value
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  cgsc_pkg::cgsc_pins_s pins = 4'ha;
  cgsc_pkg::cgsc_cfg_s  cfg;
  logic                 oe_n, dev_sda, scl, sda_h, rd_done, ack, func_wr;
  logic [7:0]           rd_byte, d;
  logic [7:0]           shadow [6];
  logic [7:0]           exp_q [$];
  logic [31:0]          seed = 32'h0001268f;
  int                   errors = 0;
  int                   n_tests = 0;
  wire                  sda_line = sda_h & (oe_n | dev_sda);

  always #5 clk = ~clk;

  cgsc_regs #(.DEV_ADDR(7'h69), .REV_ID(REV)) uut (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_SCL(scl), .I_SDA(sda_line),
    .O_SDA(dev_sda), .O_SDA_OE_N(oe_n), .I_PINS(pins), .O_CFG(cfg));

  cgsc_host host (.scl(scl), .sda_o(sda_h), .sda_i(sda_line),
    .rd_done(rd_done), .rd_byte(rd_byte));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Readback map with strap mirrors and reserved ones
  function automatic logic [7:0] exp_rd(input int i);
    case (i)
      0: exp_rd = func_wr ? shadow[0] : {shadow[0][7], REV[2:0],
                  shadow[0][3], REV[3], shadow[0][1:0]};
      1: exp_rd = {4'hf, shadow[1][3:1], pins.fs0};
      2: exp_rd = {pins.fs1, shadow[2][6], 1'b1, shadow[2][4:0]};
      3: exp_rd = shadow[3];
      5: exp_rd = {1'b1, pins.fs2, 1'b1, shadow[5][4], pins.mem_sel,
                  shadow[5][2:0]};
      default: exp_rd = 8'h00;
    endcase
  endfunction : exp_rd

  function automatic cgsc_pkg::cgsc_cfg_s exp_cfg();
    cgsc_pkg::cgsc_cfg_s c;
    c.spread_down = shadow[0][7];
    c.spread_en = shadow[0][1];
    c.tristate = shadow[0][0];
    c.freq_from_reg = shadow[0][3];
    c.freq_code = shadow[0][3] ? {shadow[0][2], shadow[0][6:4]}
                : {pins.mem_sel, pins.fs2, pins.fs1, pins.fs0};
    c.host_en = shadow[1][3:1];
    c.bus_en = {shadow[2][6], shadow[2][4:0]};
    c.mem_en = shadow[3];
    c.peri_en = {shadow[5][4], shadow[5][2:0]};
    return c;
  endfunction : exp_cfg

  task automatic snd(input logic [7:0] b, input logic want);
    host.send_byte(b, ack);
    chk(ack, want);
  endtask : snd

  // Point at index 0, then read all six indices back
  task automatic rd_all();
    for (int i = 0; i < 6; i++)
      exp_q.push_back(exp_rd(i));
    host.start_cond();
    snd(8'hd2, 1'b1);
    snd(8'h00, 1'b1);
    host.start_cond();
    snd(8'hd3, 1'b1);
    for (int i = 0; i < 6; i++)
      host.recv_byte(i == 5);
    host.stop_cond();
  endtask : rd_all

  // Read results are compared against the oldest note
  always @(posedge rd_done) begin
    if (exp_q.size() == 0) begin
      n_tests++;
      errors++;
      $display("unexpected at %0t: read with nothing expected", $time);
    end else
      chk(rd_byte, exp_q.pop_front());
  end

  // Hang guard, well beyond the roughly 140 us that the run takes
  initial begin
    #500us;
    errors++;
    $display("unexpected at %0t: run timed out", $time);
    stop_test();
  end

  initial begin
    for (int p = 0; p < 2; p++) begin
      // Mid-run reset is launched on a clock edge, unlike the link stimulus, which is timed by delays
      if (p > 0)
        @(posedge clk);
      pins <= (p == 1) ? 4'h5 : 4'ha;
      rst <= 1'b1;
      shadow = '{8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff};
      func_wr = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(cfg, exp_cfg());
      rd_all();
      // random writes across all indices, 4 ignored
      for (int k = 0; k < 3; k++) begin
        host.start_cond();
        snd(8'hd2, 1'b1);
        snd(8'h00, 1'b1);
        for (int i = 0; i < 6; i++) begin
          repeat (8) seed = lfsr(seed);
          d = seed[7:0];
          snd(d, 1'b1);
          if (i != 4)
            shadow[i] = d;
        end
        func_wr = 1'b1;
        host.stop_cond();
        repeat (2) @(posedge clk);
        #1 chk(cfg, exp_cfg());
        rd_all();
      end
    end
    // Foreign address is left unanswered
    host.start_cond();
    snd(8'ha0, 1'b0);
    host.stop_cond();
    repeat (4) @(posedge clk);
    // Every noted read result must have shown up
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule : clock_gen_serial_config_regs_tb
